// ===== rtl/fsbc_cfg.svh
`ifndef FSBC_CFG_SVH
`define FSBC_CFG_SVH
// Register byte addresses on the plain register port.
`define FSBC_ADDR_BLANK_RESULT   8'h00
`define FSBC_ADDR_PROG_OFFSET    8'h04
`define FSBC_ADDR_SUSPEND_MODE   8'h08
`define FSBC_ADDR_CLOCK_NOTIFY   8'h0C
`define FSBC_ADDR_SCAN_CTRL      8'h10
`define FSBC_ADDR_CMD_CTRL       8'h14
`define FSBC_ADDR_SEQ_STATUS     8'h18
// Field positions and values.
`define FSBC_OFFSET_W            19
`define FSBC_KEY_LSB             8
`define FSBC_KEY_VALUE           8'h1E
`define FSBC_MHZ_RESET           8'h50
`define FSBC_CMD_START_BIT       0
`define FSBC_CMD_REINIT_BIT      1
`define FSBC_AREA_WORDS          19'h00040
`define FSBC_LAST_WORD           19'h0003F
// Cycles spent per scanned word for each notified MHz; scaled by the notified value.
`define FSBC_STEP_PER_MHZ        8'h01
`endif

// ===== rtl/fsbc_pkg.sv
package fsbc_pkg;
  typedef enum logic [1:0] {FSBC_IDLE, FSBC_WAIT, FSBC_CHECK, FSBC_DONE} fsbc_state_t;
endpackage

// ===== rtl/fsbc_regs.sv
// Operation
// - Blank check ends with result flag 0 when erased, 1 when programmed.
// - First programmed location is kept as a 19-bit data-flash offset.
// - Reserved bits of the result register read as their reset value.
// - Suspend mode resets on hardware reset and on re-initialisation.
// - Mode 0 gives suspension priority, mode 1 gives erasure priority.
// - Clock notify field resets to the highest supported frequency.
// - Key byte is never stored and always reads as zero.
// - Frequency updates only while the ready flag is 1.
// - Frequency updates only when the same write carries key 1E.
// - Per-word check timing scales with the notified frequency.
// - Scan goes upward when direction is 0, downward when 1.
//
// Our own choices: strobed register access and the placing of the registers.
`include "fsbc_cfg.svh"
module fsbc_regs #(
  parameter int   OFFSET_W = `FSBC_OFFSET_W,
  parameter logic [18:0] AREA_WORDS = `FSBC_AREA_WORDS
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        word_programmed,
  output logic      [18:0] scan_addr,
  output logic             erase_suspend_policy,
  output logic      [7:0]  clock_mhz_value,
  output logic             sequencer_ready_flag
);

  fsbc_pkg::fsbc_state_t state_reg;
  logic                  blank_result_flag_reg;
  logic [18:0]           first_programmed_offset_reg;
  logic                  erase_suspend_policy_reg;
  logic [7:0]            clock_mhz_reg;
  logic                  scan_direction_bit_reg;
  logic [18:0]           scan_addr_reg;
  logic [18:0]           scan_left_reg;
  logic [15:0]           wait_cnt_reg;
  logic [31:0]           rdata_reg;
  logic                  wr_cmd;
  logic                  sequencer_reinit_bit;
  logic                  start_cmd;

  // Decode writes to the command register.
  assign wr_cmd               = reg_wr && (reg_addr == `FSBC_ADDR_CMD_CTRL);
  assign sequencer_reinit_bit = wr_cmd && reg_wdata[`FSBC_CMD_REINIT_BIT];
  assign start_cmd            = wr_cmd && reg_wdata[`FSBC_CMD_START_BIT]
                                && !sequencer_reinit_bit;

  // Wait count for one scanned word follows the notified frequency.
  function automatic logic [15:0] step_cycles(input logic [7:0] mhz);
    step_cycles = {8'h00, mhz} * {8'h00, `FSBC_STEP_PER_MHZ};
  endfunction

  // Suspend policy register, cleared by reset and re-initialisation.
  always_ff @(posedge core_clk) begin
    if (rst || sequencer_reinit_bit) begin
      erase_suspend_policy_reg <= 1'b0;
    end else if (reg_wr && reg_addr == `FSBC_ADDR_SUSPEND_MODE) begin
      erase_suspend_policy_reg <= reg_wdata[0];
    end
  end

  // Scan direction control, cleared by reset and re-initialisation.
  always_ff @(posedge core_clk) begin
    if (rst || sequencer_reinit_bit) begin
      scan_direction_bit_reg <= 1'b0;
    end else if (reg_wr && reg_addr == `FSBC_ADDR_SCAN_CTRL && state_reg == fsbc_pkg::FSBC_IDLE) begin
      scan_direction_bit_reg <= reg_wdata[0];
    end
  end

  // Frequency notification is keyed and only accepted while ready.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      clock_mhz_reg <= `FSBC_MHZ_RESET;
    end else if (reg_wr && reg_addr == `FSBC_ADDR_CLOCK_NOTIFY
                 && sequencer_ready_flag
                 && reg_wdata[15:8] == `FSBC_KEY_VALUE) begin
      clock_mhz_reg <= reg_wdata[7:0];
    end
  end

  // Blank check sequencer: walk the area one word at a time.
  always_ff @(posedge core_clk) begin
    if (rst || sequencer_reinit_bit) begin
      state_reg     <= fsbc_pkg::FSBC_IDLE;
      scan_addr_reg <= 19'h00000;
      scan_left_reg <= 19'h00000;
      wait_cnt_reg  <= 16'h0000;
    end else begin
      unique case (state_reg)
        fsbc_pkg::FSBC_IDLE: begin
          if (start_cmd) begin
            scan_addr_reg <= scan_direction_bit_reg ? (AREA_WORDS - 19'h00001) : 19'h00000;
            scan_left_reg <= AREA_WORDS;
            wait_cnt_reg  <= step_cycles(clock_mhz_reg);
            state_reg     <= fsbc_pkg::FSBC_WAIT;
          end
        end
        fsbc_pkg::FSBC_WAIT: begin
          if (wait_cnt_reg <= 16'h0001) begin
            state_reg <= fsbc_pkg::FSBC_CHECK;
          end else begin
            wait_cnt_reg <= wait_cnt_reg - 16'h0001;
          end
        end
        fsbc_pkg::FSBC_CHECK: begin
          if (word_programmed || scan_left_reg == 19'h00001) begin
            state_reg <= fsbc_pkg::FSBC_DONE;
          end else begin
            scan_addr_reg <= scan_direction_bit_reg ? scan_addr_reg - 19'h00001
                                                    : scan_addr_reg + 19'h00001;
            scan_left_reg <= scan_left_reg - 19'h00001;
            wait_cnt_reg  <= step_cycles(clock_mhz_reg);
            state_reg     <= fsbc_pkg::FSBC_WAIT;
          end
        end
        fsbc_pkg::FSBC_DONE: begin
          state_reg <= fsbc_pkg::FSBC_IDLE;
        end
      endcase
    end
  end

  // Result flag is captured when the check finishes; the offset only on a programmed hit.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      blank_result_flag_reg       <= 1'b0;
      first_programmed_offset_reg <= 19'h00000;
    end else if (state_reg == fsbc_pkg::FSBC_CHECK && !sequencer_reinit_bit) begin
      if (word_programmed) begin
        blank_result_flag_reg       <= 1'b1;
        first_programmed_offset_reg <= scan_addr_reg;
      end else if (scan_left_reg == 19'h00001) begin
        blank_result_flag_reg <= 1'b0;
      end
    end
  end

  // Read data stands in the cycle after the read strobe.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_reg <= 32'h00000000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `FSBC_ADDR_BLANK_RESULT: rdata_reg <= {31'h00000000, blank_result_flag_reg};
        `FSBC_ADDR_PROG_OFFSET:  rdata_reg <= {13'h0000, first_programmed_offset_reg};
        `FSBC_ADDR_SUSPEND_MODE: rdata_reg <= {31'h00000000, erase_suspend_policy_reg};
        `FSBC_ADDR_CLOCK_NOTIFY: rdata_reg <= {24'h000000, clock_mhz_reg};
        `FSBC_ADDR_SCAN_CTRL:    rdata_reg <= {31'h00000000, scan_direction_bit_reg};
        `FSBC_ADDR_SEQ_STATUS:   rdata_reg <= {31'h00000000, state_reg == fsbc_pkg::FSBC_IDLE};
        default:                 rdata_reg <= 32'h00000000;
      endcase
    end else begin
      rdata_reg <= 32'h00000000;
    end
  end

  // Outputs come straight from flip-flops.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sequencer_ready_flag <= 1'b1;
    end else begin
      sequencer_ready_flag <= (state_reg == fsbc_pkg::FSBC_IDLE && !start_cmd)
                              || sequencer_reinit_bit;
    end
  end

  assign reg_rdata            = rdata_reg;
  assign scan_addr            = scan_addr_reg;
  assign erase_suspend_policy = erase_suspend_policy_reg;
  assign clock_mhz_value      = clock_mhz_reg;

  // A keyed write while busy must not change the frequency.
  a_busy_write_ignored: assert property (@(posedge core_clk) disable iff (rst)
    (!sequencer_ready_flag && reg_wr && reg_addr == `FSBC_ADDR_CLOCK_NOTIFY)
    |=> $stable(clock_mhz_reg))
    else $error("frequency changed while busy");

  // A write with a wrong key must not change the frequency.
  a_bad_key_blocked: assert property (@(posedge core_clk) disable iff (rst)
    (reg_wr && reg_addr == `FSBC_ADDR_CLOCK_NOTIFY && reg_wdata[15:8] != `FSBC_KEY_VALUE)
    |=> $stable(clock_mhz_reg))
    else $error("frequency changed without key");

  // A keyed write while ready takes the new value.
  a_key_write_taken: assert property (@(posedge core_clk) disable iff (rst)
    (reg_wr && reg_addr == `FSBC_ADDR_CLOCK_NOTIFY && reg_wdata[15:8] == `FSBC_KEY_VALUE
     && sequencer_ready_flag) |=> clock_mhz_reg == $past(reg_wdata[7:0]))
    else $error("keyed write not taken");

  // Key byte and reserved result bits read as zero.
  a_key_reads_zero: assert property (@(posedge core_clk) disable iff (rst)
    (reg_rd && reg_addr == `FSBC_ADDR_CLOCK_NOTIFY) |=> reg_rdata[31:8] == 24'h000000)
    else $error("key byte read nonzero");

  a_result_reserved: assert property (@(posedge core_clk) disable iff (rst)
    (reg_rd && reg_addr == `FSBC_ADDR_BLANK_RESULT) |=> reg_rdata[31:1] == 31'h00000000)
    else $error("reserved result bits nonzero");

  // Re-initialisation clears the suspend policy.
  a_reinit_clears: assert property (@(posedge core_clk) disable iff (rst)
    sequencer_reinit_bit |=> !erase_suspend_policy)
    else $error("suspend policy survived reinit");

  // A programmed hit sets the flag and records the address.
  a_hit_recorded: assert property (@(posedge core_clk) disable iff (rst)
    (state_reg == fsbc_pkg::FSBC_CHECK && word_programmed && !sequencer_reinit_bit)
    |=> blank_result_flag_reg && first_programmed_offset_reg == $past(scan_addr_reg))
    else $error("hit not recorded");

  // An erased finish keeps the old offset.
  a_blank_keeps_off: assert property (@(posedge core_clk) disable iff (rst)
    (state_reg == fsbc_pkg::FSBC_CHECK && !word_programmed && scan_left_reg == 19'h00001
     && !sequencer_reinit_bit)
    |=> !blank_result_flag_reg && $stable(first_programmed_offset_reg))
    else $error("erased check disturbed offset");

  // Scanning steps by one in the chosen direction.
  a_scan_step: assert property (@(posedge core_clk) disable iff (rst)
    (state_reg == fsbc_pkg::FSBC_CHECK && !word_programmed && scan_left_reg != 19'h00001
     && !sequencer_reinit_bit) |=> scan_addr_reg == ($past(scan_direction_bit_reg)
     ? $past(scan_addr_reg) - 19'h00001 : $past(scan_addr_reg) + 19'h00001))
    else $error("scan step wrong");

  // The first word's wait count loads the notified number of cycles.
  a_wait_length: assert property (@(posedge core_clk) disable iff (rst)
    (start_cmd && state_reg == fsbc_pkg::FSBC_IDLE)
    |=> wait_cnt_reg == step_cycles($past(clock_mhz_reg)))
    else $error("wait count wrong");

  // A check starts from idle and falls into the first per-word wait.
  sequence s_check_start;
    start_cmd && state_reg == fsbc_pkg::FSBC_IDLE;
  endsequence

  // The first wait of a check runs with ready low.
  sequence s_first_wait;
    state_reg == fsbc_pkg::FSBC_WAIT && !sequencer_ready_flag;
  endsequence

  // Accepting a start leaves idle and drops ready on the same edge.
  a_start_busy: assert property (@(posedge core_clk) disable iff (rst)
    s_check_start |=> s_first_wait)
    else $error("start did not enter the wait state");

  // The first word checked lies at the end chosen by the direction bit.
  a_first_word: assert property (@(posedge core_clk) disable iff (rst)
    s_check_start |=> scan_addr_reg == ($past(scan_direction_bit_reg)
    ? AREA_WORDS - 19'h00001 : 19'h00000))
    else $error("first scanned word wrong");

  // Each wait step above a count of one counts down by one and stays in the wait state.
  a_wait_countdown: assert property (@(posedge core_clk) disable iff (rst)
    (state_reg == fsbc_pkg::FSBC_WAIT && wait_cnt_reg > 16'h0001 && !sequencer_reinit_bit)
    |=> state_reg == fsbc_pkg::FSBC_WAIT
    && wait_cnt_reg == $past(wait_cnt_reg) - 16'h0001)
    else $error("wait countdown wrong");

  // A finished check returns to idle on the next edge.
  a_done_to_idle: assert property (@(posedge core_clk) disable iff (rst)
    state_reg == fsbc_pkg::FSBC_DONE |=> state_reg == fsbc_pkg::FSBC_IDLE)
    else $error("check did not return to idle");

  // Ready high always means the sequencer is idle, so keyed writes are safe.
  a_ready_idle: assert property (@(posedge core_clk) disable iff (rst)
    sequencer_ready_flag |-> state_reg == fsbc_pkg::FSBC_IDLE)
    else $error("ready high while busy");

  // A hardware reset restores the highest supported frequency.
  a_reset_mhz: assert property (@(posedge core_clk)
    rst |=> clock_mhz_reg == `FSBC_MHZ_RESET)
    else $error("frequency not restored by reset");

  // A hardware reset returns the suspend policy to suspension priority.
  a_reset_policy: assert property (@(posedge core_clk)
    rst |=> !erase_suspend_policy_reg)
    else $error("suspend policy not cleared by reset");

  // A write to the mode register takes bit 0 as the policy.
  a_policy_write: assert property (@(posedge core_clk) disable iff (rst)
    (reg_wr && reg_addr == `FSBC_ADDR_SUSPEND_MODE)
    |=> erase_suspend_policy_reg == $past(reg_wdata[0]))
    else $error("suspend policy write lost");

  // A result read returns the flag that stood when it was asked for.
  a_result_read: assert property (@(posedge core_clk) disable iff (rst)
    (reg_rd && reg_addr == `FSBC_ADDR_BLANK_RESULT)
    |=> reg_rdata[0] == $past(blank_result_flag_reg))
    else $error("result read wrong");

  // Only the 19 offset bits can be nonzero in an offset read.
  a_offset_width: assert property (@(posedge core_clk) disable iff (rst)
    (reg_rd && reg_addr == `FSBC_ADDR_PROG_OFFSET)
    |=> reg_rdata[31:19] == 13'h0000)
    else $error("offset read too wide");

endmodule // fsbc_regs

// ===== tb/fsbc_regs_tb.sv
`include "fsbc_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk;
  logic        rst;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        word_programmed;
  logic [18:0] scan_addr;
  logic        erase_suspend_policy;
  logic [7:0]  clock_mhz_value;
  logic        sequencer_ready_flag;
  logic        pg_en;
  int          n_mismatch;
  int          n_compared;
  int          c2;
  int          c4;
  fsbc_regs DUT (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .word_programmed(word_programmed),
    .scan_addr(scan_addr), .erase_suspend_policy(erase_suspend_policy),
    .clock_mhz_value(clock_mhz_value), .sequencer_ready_flag(sequencer_ready_flag));
  // The clock toggles every 12.5 ns, half of its 25 ns period.
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // The flash model marks words 5 and 10 as programmed while enabled.
  always @(posedge core_clk) begin
    word_programmed <= pg_en && (scan_addr == 19'h00005 || scan_addr == 19'h0000A);
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("TB: mismatches %0d, compares %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Compares a seen value with the expected one.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One write cycle on the register port.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    #1;
  endtask
  // One read cycle; the data are checked in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  // Starts a blank check and counts the cycles until ready returns.
  task automatic run_check(output int cyc);
    wr(`FSBC_ADDR_CMD_CTRL, 32'h1);
    @(posedge core_clk);
    #1;
    cyc = 1;
    while (sequencer_ready_flag !== 1'b1 && cyc < 20000) begin
      @(posedge core_clk);
      #1;
      cyc++;
    end
    chk(sequencer_ready_flag, 1'b1);
  endtask
  // Reset values, an unmapped read and the key-guarded clock notification.
  task automatic t_reset_and_notify();
    rd(`FSBC_ADDR_BLANK_RESULT, 32'h0);
    rd(`FSBC_ADDR_CLOCK_NOTIFY, {24'h0, `FSBC_MHZ_RESET});
    rd(8'h20, 32'h0);
    wr(`FSBC_ADDR_CLOCK_NOTIFY, 32'h00001F28);
    rd(`FSBC_ADDR_CLOCK_NOTIFY, {24'h0, `FSBC_MHZ_RESET});
    wr(`FSBC_ADDR_CLOCK_NOTIFY, 32'h00001E28);
    rd(`FSBC_ADDR_CLOCK_NOTIFY, 32'h00000028);
    chk(clock_mhz_value, 8'h28);
  endtask
  // An erased area gives flag 0; eight more notified MHz add eight cycles per word.
  task automatic t_timing();
    run_check(c2);
    rd(`FSBC_ADDR_BLANK_RESULT, 32'h0);
    wr(`FSBC_ADDR_CLOCK_NOTIFY, 32'h00001E30);
    run_check(c4);
    chk(c4 > c2, 1'b1);
    chk(c4 - c2, `FSBC_AREA_WORDS * 32'h8);
    wr(`FSBC_ADDR_CLOCK_NOTIFY, 32'h00001E28);
  endtask
  // Both scan directions report their own first hit; an erased run keeps it.
  task automatic t_scan();
    pg_en = 1'b1;
    wr(`FSBC_ADDR_SCAN_CTRL, 32'h0);
    run_check(c2);
    rd(`FSBC_ADDR_BLANK_RESULT, 32'h1);
    rd(`FSBC_ADDR_PROG_OFFSET, 32'h5);
    wr(`FSBC_ADDR_SCAN_CTRL, 32'h1);
    run_check(c2);
    rd(`FSBC_ADDR_BLANK_RESULT, 32'h1);
    rd(`FSBC_ADDR_PROG_OFFSET, 32'hA);
    pg_en = 1'b0;
    run_check(c2);
    rd(`FSBC_ADDR_BLANK_RESULT, 32'h0);
    rd(`FSBC_ADDR_PROG_OFFSET, 32'hA);
  endtask
  // A notify write while busy is dropped; the result register ignores writes.
  task automatic t_busy();
    pg_en = 1'b1;
    wr(`FSBC_ADDR_CMD_CTRL, 32'h1);
    wr(`FSBC_ADDR_CLOCK_NOTIFY, 32'h00001E30);
    chk(sequencer_ready_flag, 1'b0);
    run_check(c2);
    chk(clock_mhz_value, 8'h28);
    wr(`FSBC_ADDR_BLANK_RESULT, 32'hFF);
    rd(`FSBC_ADDR_BLANK_RESULT, 32'h1);
    pg_en = 1'b0;
  endtask
  // Suspend policy follows the written bit and clears on re-initialisation.
  task automatic t_suspend();
    wr(`FSBC_ADDR_SUSPEND_MODE, 32'h1);
    rd(`FSBC_ADDR_SUSPEND_MODE, 32'h1);
    chk(erase_suspend_policy, 1'b1);
    wr(`FSBC_ADDR_CMD_CTRL, 32'h2);
    rd(`FSBC_ADDR_SUSPEND_MODE, 32'h0);
    chk(erase_suspend_policy, 1'b0);
  endtask
  // A hardware reset while the sequencer is idle restores the policy and the frequency.
  task automatic t_hw_reset();
    wr(`FSBC_ADDR_SUSPEND_MODE, 32'h1);
    wr(`FSBC_ADDR_CLOCK_NOTIFY, 32'h00001E30);
    chk(clock_mhz_value, 8'h30);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk(erase_suspend_policy, 1'b0);
    chk(sequencer_ready_flag, 1'b1);
    rd(`FSBC_ADDR_CLOCK_NOTIFY, {24'h0, `FSBC_MHZ_RESET});
  endtask
  // Cuts a hang short.
  initial begin
    repeat (50000) @(posedge core_clk);
    n_mismatch++;
    tally_and_finish();
  end
  // Main sequence: reset for ten cycles, then the scenarios.
  initial begin
    n_mismatch = 0;
    n_compared = 0;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pg_en = 1'b0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset_and_notify();
    t_timing();
    t_scan();
    t_busy();
    t_suspend();
    t_hw_reset();
    tally_and_finish();
  end
endmodule // testbench
